// >>> rtl/bit_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/100ps
`default_nettype none
module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		meta     <= async_in;
		sync_out <= meta;
	end

endmodule
`default_nettype wire

// >>> rtl/byte_fifo.sv
// single-clock fifo with registered output stage
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic             push;
	logic             pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign push     = in_valid && in_ready;
	// refill output register whenever it is empty or being taken
	assign pop      = (count != '0) && (!out_valid || out_ready);

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data  <= mem[rd_ptr];
		end else if (out_ready) begin
			out_valid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/debug_flash_data_port.sv
// two-wire debug port: link framing, flash data register, pin sharing
//
// How it works
// RULE1: 8-bit read/write flash data register at debug address 0xB4, reset zero.
// RULE2: commands, addresses and data all pass through that one register.
// RULE3: only codes 0x06, 0x07, 0x08, 0x03 are accepted as commands.
// RULE4: core is halted while the debug port is communicating.
// RULE5: once halted, debug logic owns the clock and data pins.
// RULE6: user input on the data pin stays constant while halted.
// RULE7: the shared reset/clock pin is input only, never driven.
// RULE8: host unlocks with 0x02 then 0x01; reset needed afterwards.
// RULE9: host selects the data register address before data reads or writes.
`timescale 1ns/100ps
`default_nettype none
module debug_flash_data_port
	import debug_port_pkg::*;
#(
	parameter logic [7:0] DEVICE_ID   = 8'h5C,  // arbitrary value
	parameter logic [7:0] REVISION_ID = 8'h3A,  // arbitrary value
	parameter int         DEPTH       = FIFO_DEPTH
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       debug_clock_pin,
	input  wire logic       debug_data_pin_in,
	output logic            debug_data_pin_out,
	output logic            debug_data_pin_oe_b,
	output logic            core_halt,
	output logic            prog_enabled,
	output logic            cmd_error,
	output logic            user_data_in,
	output logic            flash_byte_valid,
	output logic [7:0]      flash_byte,
	input  wire logic       flash_byte_ready,
	input  wire logic       flash_rd_valid,
	input  wire logic [7:0] flash_rd_byte,
	input  wire logic       flash_op_done
);

	// ------------------------------------------------------------
	// link-domain reset
	// ------------------------------------------------------------
	logic link_rst_b;

	bit_sync #(.WIDTH(1)) u_link_rst (
		.clk      (debug_clock_pin),
		.async_in (rst_b),
		.sync_out (link_rst_b)
	);

	// ------------------------------------------------------------
	// link domain: frame decoder on the debug clock
	// ------------------------------------------------------------
	link_state_e link_state;
	logic [2:0]  bit_cnt;
	logic [1:0]  ins;
	logic [7:0]  wr_shift;
	logic [7:0]  rd_shift;
	logic [7:0]  addr_select;
	logic [7:0]  ctl_copy;
	logic [7:0]  data_copy;
	logic [7:0]  link_wr_byte;
	logic        link_wr_is_ctl;
	logic        link_wr_tog;
	logic        link_frame_tog;
	logic [7:0]  wr_value;
	logic [7:0]  rd_value;
	logic [1:0]  full_ins;
	logic        rd_tog_l;
	logic        rd_seen_l;

	assign wr_value = {debug_data_pin_in, wr_shift[7:1]};
	assign full_ins = {ins[0], debug_data_pin_in};

	// RULE9 address select steers reads
	always_comb begin
		rd_value = 8'h00;
		if (ins[INS_BIT_ADDR]) begin
			rd_value = addr_select;
		end else begin
			case (addr_select)
				ADDR_DEVICE_ID:    rd_value = DEVICE_ID;
				ADDR_REVISION:     rd_value = REVISION_ID;
				ADDR_PROG_CONTROL: rd_value = ctl_copy;
				ADDR_PROG_DATA:    rd_value = data_copy;
				default:           rd_value = 8'h00;
			endcase
		end
	end

	always_ff @(posedge debug_clock_pin) begin
		if (!link_rst_b) begin
			link_state <= LINK_IDLE;
			bit_cnt    <= '0;
			ins        <= INS_DATA_READ;
			wr_shift   <= '0;
			rd_shift   <= '0;
			link_frame_tog <= 1'b0;
		end else begin
			case (link_state)
				LINK_IDLE: begin
					bit_cnt <= '0;
					if (!debug_data_pin_in) begin
						link_state <= LINK_INS;
						// RULE4 each frame start is signalled to the core side
						link_frame_tog <= ~link_frame_tog;
					end
				end
				LINK_INS: begin
					ins     <= full_ins;
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == INS_LAST) begin
						bit_cnt    <= '0;
						link_state <= full_ins[INS_BIT_WRITE] ? LINK_WDATA : LINK_TURN;
					end
				end
				LINK_WDATA: begin
					wr_shift <= wr_value;
					bit_cnt  <= bit_cnt + 3'h1;
					if (bit_cnt == DATA_LAST) begin
						link_state <= LINK_IDLE;
					end
				end
				LINK_TURN: begin
					rd_shift   <= {1'b0, rd_value[7:1]};
					link_state <= LINK_RDATA;
				end
				LINK_RDATA: begin
					rd_shift <= {1'b0, rd_shift[7:1]};
					bit_cnt  <= bit_cnt + 3'h1;
					if (bit_cnt == DATA_LAST) begin
						link_state <= LINK_IDLE;
					end
				end
				default: link_state <= LINK_IDLE;
			endcase
		end
	end

	// RULE5 data pin driven only during read bits
	always_ff @(posedge debug_clock_pin) begin
		if (!link_rst_b) begin
			debug_data_pin_out  <= 1'b1;
			debug_data_pin_oe_b <= 1'b1;
		end else if (link_state == LINK_TURN) begin
			debug_data_pin_out  <= rd_value[0];
			debug_data_pin_oe_b <= 1'b0;
		end else if (link_state == LINK_RDATA && bit_cnt != DATA_LAST) begin
			debug_data_pin_out <= rd_shift[0];
		end else begin
			debug_data_pin_out  <= 1'b1;
			debug_data_pin_oe_b <= 1'b1;
		end
	end

	// RULE2 writes land in address, control or data register
	always_ff @(posedge debug_clock_pin) begin
		if (!link_rst_b) begin
			addr_select    <= ADDR_SELECT_RESET;
			ctl_copy       <= PROG_CONTROL_RESET;
			link_wr_byte   <= '0;
			link_wr_is_ctl <= 1'b0;
			link_wr_tog    <= 1'b0;
		end else if (link_state == LINK_WDATA && bit_cnt == DATA_LAST) begin
			if (ins[INS_BIT_ADDR]) begin
				addr_select <= wr_value;
			end else if (addr_select == ADDR_PROG_CONTROL || addr_select == ADDR_PROG_DATA) begin
				link_wr_byte   <= wr_value;
				link_wr_is_ctl <= (addr_select == ADDR_PROG_CONTROL);
				link_wr_tog    <= ~link_wr_tog;
				if (addr_select == ADDR_PROG_CONTROL) begin
					ctl_copy <= wr_value;
				end
			end
		end
	end

	bit_sync #(.WIDTH(1)) u_rd_tog_sync (
		.clk      (debug_clock_pin),
		.async_in (rd_tog_l),
		.sync_out (rd_seen_l)
	);

	// RULE1 link copy of the data register for host reads
	logic rd_taken_l;
	always_ff @(posedge debug_clock_pin) begin
		if (!link_rst_b) begin
			data_copy  <= PROG_DATA_RESET;
			rd_taken_l <= 1'b0;
		end else if (link_state == LINK_WDATA && bit_cnt == DATA_LAST && !ins[INS_BIT_ADDR]
				&& addr_select == ADDR_PROG_DATA) begin
			data_copy <= wr_value;
		end else if (rd_seen_l != rd_taken_l) begin
			// core copy is steady once toggled; a host write in this window may race it
			data_copy  <= flash_program_data;
			rd_taken_l <= rd_seen_l;
		end
	end

	// ------------------------------------------------------------
	// core domain
	// ------------------------------------------------------------
	logic        wr_tog_s;
	logic        frame_tog_s;
	logic        pin_s;
	logic        wr_seen;
	logic        frame_seen;
	logic        new_wr;
	logic        pend_valid;
	logic [7:0]  pend_byte;
	logic        fifo_in_ready;
	logic        cmd_expected;
	logic [7:0]  flash_program_data;
	prog_state_e prog_state;
	logic        cmd_valid;

	bit_sync #(.WIDTH(3)) u_sys_sync (
		.clk      (sys_clk),
		.async_in ({link_wr_tog, link_frame_tog, debug_data_pin_in}),
		.sync_out ({wr_tog_s, frame_tog_s, pin_s})
	);

	// a held byte stalls the next capture until the fifo has room
	assign new_wr = (wr_tog_s != wr_seen) && !pend_valid;

	// RULE3 command code check
	assign cmd_valid = (link_wr_byte == CMD_BLOCK_READ) || (link_wr_byte == CMD_BLOCK_WRITE)
		|| (link_wr_byte == CMD_PAGE_ERASE) || (link_wr_byte == CMD_DEVICE_ERASE);

	// RULE8 unlock sequence, left only by reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prog_state <= PROG_LOCKED;
		end else if (new_wr && link_wr_is_ctl) begin
			case (prog_state)
				PROG_LOCKED: prog_state <= (link_wr_byte == UNLOCK_FIRST) ? PROG_HALF : PROG_LOCKED;
				PROG_HALF: begin
					if (link_wr_byte == UNLOCK_SECOND) begin
						prog_state <= PROG_OPEN;
					end else if (link_wr_byte != UNLOCK_FIRST) begin
						prog_state <= PROG_LOCKED;
					end
				end
				PROG_OPEN: prog_state <= PROG_OPEN;
				default:   prog_state <= PROG_LOCKED;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prog_enabled <= 1'b0;
		end else begin
			prog_enabled <= (prog_state == PROG_OPEN);
		end
	end

	// RULE1 core copy of the data register
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			flash_program_data <= PROG_DATA_RESET;
			rd_tog_l           <= 1'b0;
		end else if (new_wr && !link_wr_is_ctl) begin
			flash_program_data <= link_wr_byte;
		end else if (flash_rd_valid) begin
			flash_program_data <= flash_rd_byte;
			rd_tog_l           <= ~rd_tog_l;
		end
	end

	// RULE3 only valid codes start a flash operation
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wr_seen      <= 1'b0;
			pend_valid   <= 1'b0;
			pend_byte    <= '0;
			cmd_expected <= 1'b1;
			cmd_error    <= 1'b0;
		end else begin
			if (pend_valid && fifo_in_ready) begin
				pend_valid <= 1'b0;
			end
			if (new_wr) begin
				wr_seen <= wr_tog_s;
				if (!link_wr_is_ctl && prog_state == PROG_OPEN) begin
					if (!cmd_expected || cmd_valid) begin
						pend_valid   <= 1'b1;
						pend_byte    <= link_wr_byte;
						cmd_expected <= 1'b0;
					end else begin
						cmd_error <= 1'b1;
					end
				end
			end
			// a finishing operation wins over a capture
			if (flash_op_done) begin
				cmd_expected <= 1'b1;
			end
		end
	end

	// RULE4 halt the core from the first frame until reset
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			frame_seen <= 1'b0;
			core_halt  <= 1'b0;
		end else if (frame_tog_s != frame_seen) begin
			frame_seen <= frame_tog_s;
			core_halt  <= 1'b1;
		end
	end

	// RULE6 user view of the data pin frozen while halted
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			user_data_in <= 1'b1;
		end else if (!core_halt) begin
			user_data_in <= pin_s;
		end
	end

	// RULE7 the clock pin is only ever an input here

	// ------------------------------------------------------------
	// byte stream toward the flash controller
	// ------------------------------------------------------------
	byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.in_valid  (pend_valid),
		.in_data   (pend_byte),
		.in_ready  (fifo_in_ready),
		.out_valid (flash_byte_valid),
		.out_data  (flash_byte),
		.out_ready (flash_byte_ready)
	);

endmodule
`default_nettype wire

// >>> rtl/debug_port_pkg.sv
// constants and types shared by the two-wire debug flash port
package debug_port_pkg;

	// ------------------------------------------------------------
	// debug register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_DEVICE_ID    = 8'h00;
	localparam logic [7:0] ADDR_REVISION     = 8'h01;
	localparam logic [7:0] ADDR_PROG_CONTROL = 8'h02;
	localparam logic [7:0] ADDR_PROG_DATA    = 8'hB4;

	// ------------------------------------------------------------
	// reset values and unlock sequence
	// ------------------------------------------------------------
	localparam logic [7:0] PROG_DATA_RESET    = 8'h00;
	localparam logic [7:0] PROG_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ADDR_SELECT_RESET  = 8'h00;
	localparam logic [7:0] UNLOCK_FIRST       = 8'h02;
	localparam logic [7:0] UNLOCK_SECOND      = 8'h01;

	// ------------------------------------------------------------
	// flash command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_BLOCK_READ   = 8'h06;
	localparam logic [7:0] CMD_BLOCK_WRITE  = 8'h07;
	localparam logic [7:0] CMD_PAGE_ERASE   = 8'h08;
	localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

	// ------------------------------------------------------------
	// link framing: start bit, 2 instruction bits msb first,
	// then 8 data bits lsb first
	// ------------------------------------------------------------
	localparam logic [1:0] INS_DATA_READ  = 2'h0;
	localparam logic [1:0] INS_DATA_WRITE = 2'h1;
	localparam logic [1:0] INS_ADDR_READ  = 2'h2;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
	localparam int         INS_BIT_WRITE  = 0;
	localparam int         INS_BIT_ADDR   = 1;
	localparam logic [2:0] INS_LAST       = 3'h1;
	localparam logic [2:0] DATA_LAST      = 3'h7;
	localparam int         FIFO_DEPTH     = 32;

	typedef enum logic [2:0] {
		LINK_IDLE  = 3'b000,
		LINK_INS   = 3'b001,
		LINK_WDATA = 3'b011,
		LINK_TURN  = 3'b101,
		LINK_RDATA = 3'b100
	} link_state_e;

	typedef enum logic [1:0] {
		PROG_LOCKED = 2'b00,
		PROG_HALF   = 2'b01,
		PROG_OPEN   = 2'b11
	} prog_state_e;

endpackage

// >>> tb/debug_host.sv
// behavioural debug host driving the two-wire link
`timescale 1ns/100ps
`default_nettype none
module debug_host (
	output logic      debug_clock_pin,
	output wire logic debug_data_pin_in,
	input  wire logic debug_data_pin_out,
	input  wire logic debug_data_pin_oe_b
);
	// ------------------------------------------------------------
	// pin resolution and framing
	// ------------------------------------------------------------
	logic host_oe;
	logic host_drive;
	// pull-up holds the wire high once both sides let go
	assign debug_data_pin_in = !debug_data_pin_oe_b ? debug_data_pin_out : (host_oe ? host_drive : 1'b1);
	initial begin
		debug_clock_pin = 1'b0;
		host_oe = 1'b0;
		host_drive = 1'b1;
	end
	// clock stands still low between pulses
	task automatic pulse(input int n);
		repeat (n) begin
			#32 debug_clock_pin = 1'b1;
			#32 debug_clock_pin = 1'b0;
		end
	endtask
	task automatic frame(input logic [1:0] ins, input logic [7:0] wdat, output logic [7:0] rdat);
		logic [10:0] bits;
		bits = {wdat, ins[0], ins[1], 1'b0};
		rdat = 8'h00;
		for (int i = 0; i < 13; i++) begin
			host_oe = (i < 11) && (i < 3 || ins[0]);
			host_drive = (i < 11) ? bits[i] : 1'b1;
			pulse(1);
			if (!ins[0] && i >= 3 && i <= 10)
				rdat[i-3] = debug_data_pin_in;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/debug_port_props.sv
// concurrent checks on the debug flash port pins
`timescale 1ns/100ps
`default_nettype none
module debug_port_props (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic       debug_clock_pin,
	input wire logic       debug_data_pin_out,
	input wire logic       debug_data_pin_oe_b,
	input wire logic       core_halt,
	input wire logic       prog_enabled,
	input wire logic       cmd_error,
	input wire logic       user_data_in,
	input wire logic       flash_byte_valid,
	input wire logic [7:0] flash_byte,
	input wire logic       flash_byte_ready
);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	// reset term is the trigger here, so it cannot also disable
	chk_reset_values: assert property (@(posedge sys_clk) !rst_b |=>
		!core_halt && !prog_enabled && !cmd_error && !flash_byte_valid && flash_byte == 8'h00)
		else $error("outputs not at reset value");
	chk_read_window: assert property (@(posedge debug_clock_pin) disable iff (!rst_b)
		$fell(debug_data_pin_oe_b) |-> (!debug_data_pin_oe_b)[*8] ##1 debug_data_pin_oe_b)
		else $error("read drive window not eight bits");
	chk_idle_high: assert property (@(posedge debug_clock_pin) disable iff (!rst_b)
		debug_data_pin_oe_b |-> debug_data_pin_out) else $error("idle drive value low");
	chk_drive_halted: assert property (@(posedge debug_clock_pin) disable iff (!rst_b)
		!debug_data_pin_oe_b |-> core_halt) else $error("pin driven while running");
	chk_halt_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
		core_halt |=> core_halt) else $error("halt dropped");
	chk_prog_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
		prog_enabled |=> prog_enabled) else $error("programming enable dropped");
	chk_error_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(cmd_error) |=> cmd_error[*4]) else $error("command error not sticky");
	chk_user_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
		core_halt && $past(core_halt) |-> $stable(user_data_in)) else $error("user input moved");
	chk_byte_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
		flash_byte_valid && !flash_byte_ready |=> flash_byte_valid && $stable(flash_byte))
		else $error("stream byte not held");
	chk_locked_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		flash_byte_valid |-> prog_enabled) else $error("byte streamed while locked");
	cov_unlock: cover property (@(posedge sys_clk) $rose(prog_enabled));
	cov_error: cover property (@(posedge sys_clk) $rose(cmd_error));
	cov_stall: cover property (@(posedge sys_clk) flash_byte_valid && !flash_byte_ready ##1 flash_byte_ready);
endmodule
bind debug_flash_data_port debug_port_props debug_port_props_i (.sys_clk, .rst_b, .debug_clock_pin,
	.debug_data_pin_out, .debug_data_pin_oe_b, .core_halt, .prog_enabled, .cmd_error, .user_data_in,
	.flash_byte_valid, .flash_byte, .flash_byte_ready);
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the debug flash data port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import debug_port_pkg::*;
	// ------------------------------------------------------------
	// signals, instances, tasks
	// ------------------------------------------------------------
	logic       sys_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       flash_byte_ready = 1'b0;
	logic       flash_rd_valid = 1'b0;
	logic       flash_op_done = 1'b0;
	logic [7:0] flash_rd_byte = 8'h00;
	wire logic  link_clk, pin_in, pin_out, oe_b, core_halt, prog_enabled, cmd_error, user_data_in, byte_valid;
	wire logic [7:0] flash_byte;
	int         failures = 0;
	int         check_count = 0;
	logic [7:0] got_q[$];
	logic [7:0] rd;
	logic [7:0] cmds[4] = '{CMD_BLOCK_READ, CMD_BLOCK_WRITE, CMD_PAGE_ERASE, CMD_DEVICE_ERASE};
	// identity values are arbitrary, picked only to tell the two reads apart
	localparam logic [7:0] ID_VALUE  = 8'h3D;
	localparam logic [7:0] REV_VALUE = 8'h6E;
	always #10 sys_clk = ~sys_clk;
	debug_host debug_host_i (.debug_clock_pin(link_clk), .debug_data_pin_in(pin_in),
		.debug_data_pin_out(pin_out), .debug_data_pin_oe_b(oe_b));
	debug_flash_data_port #(.DEVICE_ID(ID_VALUE), .REVISION_ID(REV_VALUE)) debug_flash_data_port_i (
		.sys_clk(sys_clk), .rst_b(rst_b),
		.debug_clock_pin(link_clk), .debug_data_pin_in(pin_in), .debug_data_pin_out(pin_out),
		.debug_data_pin_oe_b(oe_b), .core_halt(core_halt), .prog_enabled(prog_enabled),
		.cmd_error(cmd_error), .user_data_in(user_data_in), .flash_byte_valid(byte_valid),
		.flash_byte(flash_byte), .flash_byte_ready(flash_byte_ready), .flash_rd_valid(flash_rd_valid),
		.flash_rd_byte(flash_rd_byte), .flash_op_done(flash_op_done));
	always @(posedge sys_clk)
		if (byte_valid === 1'b1 && flash_byte_ready === 1'b1)
			got_q.push_back(flash_byte);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// link logic resets through a synchroniser, so it needs link edges
	task automatic do_reset;
		@(negedge sys_clk) rst_b = 1'b0;
		fork
			debug_host_i.pulse(4);
			repeat (6) @(negedge sys_clk);
		join
		@(negedge sys_clk) rst_b = 1'b1;
		debug_host_i.pulse(4);
	endtask
	task automatic sel(input logic [7:0] a);
		debug_host_i.frame(INS_ADDR_WRITE, a, rd);
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic put(input logic [7:0] d);
		debug_host_i.frame(INS_DATA_WRITE, d, rd);
		repeat (8) @(negedge sys_clk);
	endtask
	task automatic get(output logic [7:0] v);
		debug_host_i.frame(INS_DATA_READ, 8'h00, v);
	endtask
	task automatic done_pulse;
		@(negedge sys_clk) flash_op_done = 1'b1;
		@(negedge sys_clk) flash_op_done = 1'b0;
	endtask
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		do_reset;
		check("halt at reset", core_halt, 1'b0);
		check("oe_b at reset", oe_b, 1'b1);
		check("user in", user_data_in, 1'b1);
		sel(ADDR_PROG_DATA);
		check("halt", core_halt, 1'b1);
		get(rd);
		check("data reset", rd, PROG_DATA_RESET);
		put(8'hA5);
		get(rd);
		check("data rw", rd, 8'hA5);
		check("oe_b after read", oe_b, 1'b1);
		check("locked stream", byte_valid, 1'b0);
		sel(8'h10);
		get(rd);
		check("unmapped", rd, 8'h00);
		sel(ADDR_DEVICE_ID);
		put(8'h77);
		get(rd);
		check("device id", rd, ID_VALUE);
		sel(ADDR_REVISION);
		get(rd);
		check("revision", rd, REV_VALUE);
		sel(ADDR_PROG_CONTROL);
		put(UNLOCK_FIRST);
		check("half unlock", prog_enabled, 1'b0);
		put(UNLOCK_SECOND);
		check("unlocked", prog_enabled, 1'b1);
		get(rd);
		check("control rb", rd, UNLOCK_SECOND);
		debug_host_i.frame(INS_ADDR_READ, 8'h00, rd);
		check("select rb", rd, ADDR_PROG_CONTROL);
		sel(ADDR_PROG_DATA);
		@(negedge sys_clk) flash_byte_ready = 1'b1;
		foreach (cmds[i]) begin
			got_q.delete();
			put(cmds[i]);
			put(8'h40 + 8'(i));
			check("count", 8'(got_q.size()), 8'h02);
			check("command", got_q[0], cmds[i]);
			check("address", got_q[1], 8'h40 + 8'(i));
			done_pulse;
		end
		check("no error", cmd_error, 1'b0);
		got_q.delete();
		put(8'h05);
		check("bad code", cmd_error, 1'b1);
		check("bad dropped", 8'(got_q.size()), 8'h00);
		done_pulse;
		@(negedge sys_clk) begin
			flash_rd_valid = 1'b1;
			flash_rd_byte = 8'h3C;
		end
		@(negedge sys_clk) flash_rd_valid = 1'b0;
		repeat (4) @(negedge sys_clk);
		debug_host_i.pulse(4);
		get(rd);
		check("flash read", rd, 8'h3C);
		@(negedge sys_clk) flash_byte_ready = 1'b0;
		put(CMD_BLOCK_WRITE);
		for (int i = 0; i < 32; i++)
			put(8'(i));
		check("stalled valid", byte_valid, 1'b1);
		@(negedge sys_clk) flash_byte_ready = 1'b1;
		repeat (40) @(negedge sys_clk);
		check("drained", 8'(got_q.size()), 8'd33);
		check("fill cmd", got_q[0], CMD_BLOCK_WRITE);
		for (int i = 0; i < 32; i++)
			check("fill data", got_q[i+1], 8'(i));
		check("empty", byte_valid, 1'b0);
		do_reset;
		check("relocked", prog_enabled, 1'b0);
		check("error cleared", cmd_error, 1'b0);
		check("halt cleared", core_halt, 1'b0);
		check("user idle", user_data_in, 1'b1);
		results;
	end
	// the sequence needs about 60 us; the limit leaves wide margin
	initial begin
		#1500000;
		failures++;
		results;
	end
endmodule
`default_nettype wire
